/* File: hdl/sram_host_pkg.sv */
package sram_host_pkg;

    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;

    // Pin timing of the slowest speed grade, in nanoseconds.
    localparam int CLK_PERIOD_NS = 40;
    localparam int T_ACCESS_NS   = 70;
    localparam int T_GATE_ACC_NS = 25;
    localparam int T_WRITE_P_NS  = 50;
    localparam int T_DSETUP_NS   = 25;
    localparam int T_OFF_NS      = 25;
    localparam int T_OUT_HOLD_NS = 5;

    // Least times round up to whole cycles.
    localparam int ACCESS_CYC =
        (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int write_pulse_min_cyc =
        (T_WRITE_P_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OFF_CYC =
        (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
    localparam logic [CNT_W-1:0] ACCESS_LOAD = CNT_W'(ACCESS_CYC);
    localparam logic [CNT_W-1:0] WRITE_LOAD  = CNT_W'(write_pulse_min_cyc);
    localparam logic [CNT_W-1:0] OFF_LOAD    = CNT_W'(OFF_CYC);

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] word_index;
        logic [DATA_W-1:0] wdata;
    } request_s;

    typedef struct packed {
        logic              select_active_low;
        logic              select_active_high;
        logic              write_strobe_n;
        logic              output_gate_n;
        logic [ADDR_W-1:0] word_index;
    } pins_s;

    typedef enum logic [2:0] {
        IDLE,
        SETUP,
        READ_WAIT,
        WRITE_PULSE,
        WRITE_HOLD,
        RECOVER
    } state_e;

endpackage

/* File: hdl/cycle_timer.sv */
module cycle_timer
    import sram_host_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] value,
    output logic                  done
);

    logic [CNT_W-1:0] count;

    assign done = (count == CNT_ZERO) && !load;

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= CNT_ZERO;
        end else if (load) begin
            count <= value;
        end else if (count != CNT_ZERO) begin
            count <= count - CNT_ONE;
        end
    end

endmodule

/* File: hdl/sram_host.sv */
module sram_host
    import sram_host_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              req_valid,
    input  request_s               req,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    output pins_s                  pins,
    input  wire logic [DATA_W-1:0] data_lines_in,
    output logic [DATA_W-1:0]      data_lines_out,
    output logic                   data_lines_oe_n
);

    state_e            state;
    state_e            next_state;
    request_s          held;
    logic              selected;
    logic              gate_open;
    logic              strobe_low;
    logic              drive_bus;
    logic              timer_load;
    logic [CNT_W-1:0]  timer_value;
    logic              timer_done;
    logic [DATA_W-1:0] sync_a;
    logic [DATA_W-1:0] sync_b;
    logic              take;
    logic              read_end;
    logic              sample_due;

    // The data pins come from outside, so two flops sit before any use.
    always_ff @(posedge clk) begin
        sync_a <= data_lines_in;
        sync_b <= sync_a;
    end

    cycle_timer timer (
        .clk   (clk),
        .rst   (rst),
        .load  (timer_load),
        .value (timer_value),
        .done  (timer_done)
    );

    assign take      = (state == IDLE) && req_valid;
    assign read_end  = (state == READ_WAIT) && timer_done;
    assign req_ready = (state == IDLE);

    // The chip is selected only while an access is in flight.
    assign selected   = (state == SETUP) || (state == READ_WAIT) ||
                        (state == WRITE_PULSE) ||
                        (state == WRITE_HOLD);
    // The gate opens only for reads, so no write can meet a live driver.
    assign gate_open  = (state == READ_WAIT) && !held.write;
    assign strobe_low = (state == WRITE_PULSE);
    // Data is driven from setup to one cycle past the strobe rising.
    assign drive_bus  = held.write && ((state == SETUP) ||
                        (state == WRITE_PULSE) ||
                        (state == WRITE_HOLD));

    always_comb begin
        next_state  = state;
        timer_load  = 1'b0;
        timer_value = CNT_ZERO;
        case (state)
            IDLE: begin
                if (req_valid) begin
                    next_state = SETUP;
                end
            end
            // Address and select settle a full cycle before the strobe.
            SETUP: begin
                timer_load = 1'b1;
                if (held.write) begin
                    timer_value = WRITE_LOAD;
                    next_state  = WRITE_PULSE;
                end else begin
                    timer_value = ACCESS_LOAD;
                    next_state  = READ_WAIT;
                end
            end
            READ_WAIT: begin
                if (timer_done) begin
                    next_state = RECOVER;
                end
            end
            WRITE_PULSE: begin
                if (timer_done) begin
                    next_state = WRITE_HOLD;
                end
            end
            // Address stays put one cycle after the strobe rises.
            WRITE_HOLD: begin
                timer_load  = 1'b1;
                timer_value = OFF_LOAD;
                next_state  = RECOVER;
            end
            // Drivers of the device need time to float after deselect.
            RECOVER: begin
                if (timer_done) begin
                    next_state = IDLE;
                end
            end
            default: begin
                next_state = IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            held <= '0;
        end else if (take) begin
            held <= req;
        end
    end

    // The reply waits one cycle past the access count, so the second sync
    // flop holds a word that the first caught after the access time.
    always_ff @(posedge clk) begin
        if (rst) begin
            sample_due <= 1'b0;
            rsp_valid  <= 1'b0;
            rsp_data   <= '0;
        end else begin
            sample_due <= read_end;
            rsp_valid  <= sample_due;
            if (sample_due) begin
                rsp_data <= sync_b;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pins            <= '{1'b1, 1'b0, 1'b1, 1'b1, '0};
            data_lines_out  <= '0;
            data_lines_oe_n <= 1'b1;
        end else begin
            pins.select_active_low  <= !selected;
            pins.select_active_high <= selected;
            pins.write_strobe_n     <= !strobe_low;
            pins.output_gate_n      <= !gate_open;
            pins.word_index         <= held.word_index;
            data_lines_out          <= held.wdata;
            data_lines_oe_n         <= !drive_bus;
        end
    end

endmodule

/* File: testbench/sram_model.sv */
module sram_model
    import sram_host_pkg::*;
(
    input pins_s                  pins,
    input wire logic [DATA_W-1:0] host_data,
    input wire logic              host_oe_n,
    output logic [DATA_W-1:0]     bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] mem [2**ADDR_W];
    wire sel = !pins.select_active_low && pins.select_active_high;
    wire on  = !pins.output_gate_n;
    wire drv = sel && on && pins.write_strobe_n;
    // Inertial delays restart at every edge, so a word is valid only a
    // full access after the last index or select change.
    wire [ADDR_W:0] look = {sel, pins.word_index};
    wire [ADDR_W:0] #(T_ACCESS_NS) look_acc = look;
    wire [ADDR_W:0] #(T_OUT_HOLD_NS) look_old = look;
    wire #(T_GATE_ACC_NS) gate_acc = on;
    wire ok = (look_acc == look_old) && gate_acc;
    // Until valid the lines show the inverse word, so early sampling fails.
    wire [DATA_W-1:0] q = (drv && ok) ? mem[look_old[ADDR_W-1:0]]
                                      : ~mem[pins.word_index];
    always @(posedge pins.write_strobe_n)
        if (sel) mem[pins.word_index] = host_data;
    always @(negedge sel)
        if (!pins.write_strobe_n) mem[pins.word_index] = host_data;
    assign bus = !host_oe_n ? host_data : q;
endmodule

/* File: testbench/sram_host_assertions.sv */
module sram_host_assertions
    import sram_host_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              req_valid,
    input request_s               req,
    input wire logic              req_ready,
    input wire logic              rsp_valid,
    input pins_s                  pins,
    input wire logic [DATA_W-1:0] data_lines_out,
    input wire logic              data_lines_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire g   = pins.output_gate_n;
    wire we  = !pins.write_strobe_n;
    wire sel = !pins.select_active_low && pins.select_active_high;
    wire on  = sel && !g && !we;
    wire rd  = req_valid && req_ready && !req.write;
    sequence low_min; we [*2]; endsequence
    sequence answer; ##[5:8] rsp_valid; endsequence
    a_gate_write: assert property (we |-> g)
        else $error("gate low in write");
    a_drive_gate: assert property (!data_lines_oe_n |-> g)
        else $error("host drives while gate low");
    a_write_sel: assert property (we |-> sel)
        else $error("strobe without select");
    a_index_hold: assert property (we |=> $stable(pins.word_index))
        else $error("index moved in write");
    a_pulse_width: assert property ($rose(we) |-> low_min)
        else $error("strobe pulse short");
    a_data_hold: assert property ($rose(pins.write_strobe_n) |->
        !data_lines_oe_n && $stable(data_lines_out))
        else $error("data moved at write end");
    a_read_answer: assert property (rd |-> answer)
        else $error("no read answer");
    a_access_wait: assert property ($rose(rsp_valid) |-> $past(on, 2))
        else $error("answer before access time");
endmodule
bind sram_host sram_host_assertions sram_host_assertions_inst (
    .clk, .rst, .req_valid, .req, .req_ready, .rsp_valid, .pins,
    .data_lines_out, .data_lines_oe_n);

/* File: testbench/testbench.sv */
module testbench
    import sram_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              req_valid = 1'b0;
    request_s          req = '0;
    logic              req_ready, rsp_valid, data_lines_oe_n;
    logic [DATA_W-1:0] rsp_data, data_lines_out, bus;
    pins_s             pins;
    int                num_errors = 0;
    int                check_count = 0;
    logic [ADDR_W-1:0] ta [3] = '{13'h0000, 13'h1fff, 13'h0aa5};
    logic [DATA_W-1:0] td [3] = '{8'ha5, 8'h5a, 8'h3c};
    sram_host sram_host_inst (.clk, .rst, .req_valid, .req, .req_ready,
        .rsp_valid, .rsp_data, .pins, .data_lines_in(bus),
        .data_lines_out, .data_lines_oe_n);
    sram_model sram_model_inst (.pins, .host_data(data_lines_out),
        .host_oe_n(data_lines_oe_n), .bus);
    initial forever #20 clk = ~clk;
    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic xfer(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        req = {w, a, d};
        for (n = 0; n < 30 && req_ready !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
    endtask
    // The answer is a one-cycle pulse, so it is polled at every low phase.
    task automatic read_chk(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        int n;
        xfer(1'b0, a, 8'h00);
        for (n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(negedge clk);
        check("rsp_valid", 16'h0001, {15'h0, rsp_valid});
        check("rsp_data", {8'h0, d}, {8'h0, rsp_data});
    endtask
    task automatic t_idle;
        check("pins", 16'h000b, {12'h0, pins.select_active_low,
            pins.select_active_high, pins.write_strobe_n, pins.output_gate_n});
        check("oe_n", 16'h0001, {15'h0, data_lines_oe_n});
        check("req_ready", 16'h0001, {15'h0, req_ready});
    endtask
    task automatic t_fill;
        foreach (ta[i]) xfer(1'b1, ta[i], td[i]);
        foreach (ta[i]) read_chk(ta[i], td[i]);
    endtask
    task automatic t_overwrite;
        xfer(1'b1, 13'h1fff, 8'hc3);
        read_chk(13'h1fff, 8'hc3);
        read_chk(13'h0aa5, 8'h3c);
        read_chk(13'h0000, 8'ha5);
    endtask
    task automatic t_gap;
        read_chk(13'h0aa5, 8'h3c);
        repeat (25) @(negedge clk);
        read_chk(13'h0aa5, 8'h3c);
        t_idle();
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_idle();
        t_fill();
        t_overwrite();
        t_gap();
        conclude();
    end
    initial begin
        repeat (2000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule
